// ===== logic/pdb_defines.svh
// Purpose: Constants for the breakpoint comparator block.
// Assumes: Debug control register numbers are 4 bits wide.
// Notes: Register offsets are debug control register numbers.
`ifndef PDB_DEFINES_SVH
`define PDB_DEFINES_SVH
// ==========================================================
// Register numbers
`define PDB_REG_TRIGGER 4'h7
`define PDB_REG_PC_ADDR 4'h8
`define PDB_REG_PC_MASK 4'h9
`define PDB_REG_DATA_VAL 4'hE
`define PDB_REG_DATA_MASK 4'hF
// ==========================================================
// Reset values
`define PDB_TRIG_RESET 32'h0000_0000
`define PDB_WORD_RESET 32'h0000_0000
// ==========================================================
// Trigger definition fields within one 16-bit level half
`define PDB_F_TRC_HI 15
`define PDB_F_TRC_LO 14
`define PDB_F_EBL 13
`define PDB_F_EDLW 12
`define PDB_F_EDWL 11
`define PDB_F_EDWU 10
`define PDB_F_EDLL 9
`define PDB_F_EDLM 8
`define PDB_F_EDUM 7
`define PDB_F_EDUU 6
`define PDB_F_DI 5
`define PDB_F_EPC 1
`define PDB_F_PCI 0
`define PDB_L2_SEL 15
`define PDB_L1_SEL 14
// ==========================================================
// Size codes and response codes
`define PDB_SZ_LONG 2'h0
`define PDB_SZ_BYTE 2'h1
`define PDB_SZ_WORD 2'h2
`define PDB_RSP_SHOW 2'h0
`define PDB_RSP_HALT 2'h1
`define PDB_RSP_IRQ 2'h2
`endif

// ===== logic/pdb_pkg.sv
// Purpose: Types for the breakpoint comparator block.
// Assumes: Nothing beyond the defines header.
// Notes: Holds the state machine encoding.
package pdb_pkg;
    // ==========================================================
    // Trigger sequencing state, Gray coded along the usual path
    typedef enum logic [1:0]
    {
        PDB_LEVEL1 = 2'h0,
        PDB_LEVEL2 = 2'h1,
        PDB_FIRED = 2'h3
    } pdb_state_t;
endpackage

// ===== logic/pdb_breakpoint.sv
// Purpose: PC and data breakpoint compare with one or two level trigger.
// Assumes: Bus and core inputs are on clk; the debug port pins are not.
// Notes: Register numbers follow the debug control register map.
`timescale 1ns/1ps
`include "pdb_defines.svh"

module pdb_breakpoint
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic supWriteValid,
    input wire logic [3:0] supWriteReg,
    input wire logic [31:0] supWriteData,
    input wire logic portWriteStrobe,
    input wire logic portReadStrobe,
    input wire logic [3:0] portRegNum,
    input wire logic [31:0] portWriteData,
    input wire logic portMemValid,
    input wire logic [31:0] portMemData,
    input wire logic pcValid,
    input wire logic [31:0] pcValue,
    input wire logic busDataValid,
    input wire logic [31:0] busData,
    input wire logic [1:0] busAddrLow,
    input wire logic [1:0] busSize,
    output logic [31:0] portReadData,
    output logic portReadValid,
    output logic pcMatch,
    output logic dataMatch,
    output logic triggerShow,
    output logic haltRequest,
    output logic debugInterrupt
);

    // ==========================================================
    // Synchronisers for the debug serial port strobes
    logic [1:0] wrSync_reg;
    logic [1:0] rdSync_reg;
    logic [1:0] memSync_reg;
    logic wrSeen_reg;
    logic rdSeen_reg;
    logic memSeen_reg;
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            wrSync_reg <= 2'h0;
            rdSync_reg <= 2'h0;
            memSync_reg <= 2'h0;
            wrSeen_reg <= 1'b0;
            rdSeen_reg <= 1'b0;
            memSeen_reg <= 1'b0;
        end
        else
        begin
            wrSync_reg <= {wrSync_reg[0], portWriteStrobe};
            rdSync_reg <= {rdSync_reg[0], portReadStrobe};
            memSync_reg <= {memSync_reg[0], portMemValid};
            wrSeen_reg <= wrSync_reg[1];
            rdSeen_reg <= rdSync_reg[1];
            memSeen_reg <= memSync_reg[1];
        end
    end
    // Port data and register number must stay stable while a strobe is high.
    wire logic portWr = wrSync_reg[1] & ~wrSeen_reg;
    wire logic portRd = rdSync_reg[1] & ~rdSeen_reg;
    wire logic portMem = memSync_reg[1] & ~memSeen_reg;

    // ==========================================================
    // State
    typedef struct packed
    {
        logic [31:0] trig;
        logic [31:0] pcAddr;
        logic [31:0] pcMask;
        logic [31:0] dataVal;
        logic [31:0] dataMask;
        pdb_pkg::pdb_state_t state;
        logic [31:0] readData;
        logic readValid;
        logic pcHit;
        logic dataHit;
        logic show;
        logic halt;
        logic irq;
    } pdb_regs_t;

    pdb_regs_t st_reg;
    pdb_regs_t st_next;

    logic [31:0] laneMask;
    logic [31:0] dataRaw;
    logic pcRaw;
    logic [15:0] lvl;
    logic pcCond;
    logic dataCond;
    logic dataEn;
    logic fire;
    logic [3:0] wrReg;
    logic [31:0] wrData;
    logic wrAny;

    always_comb
    begin
        st_next = st_reg;
        st_next.readValid = 1'b0;
        st_next.pcHit = 1'b0;
        st_next.dataHit = 1'b0;
        st_next.show = 1'b0;
        st_next.halt = 1'b0;
        st_next.irq = 1'b0;
        // Supervisor writes take priority; a port write in the same cycle is dropped.
        wrAny = supWriteValid | portWr;
        wrReg = supWriteValid ? supWriteReg : portRegNum;
        wrData = supWriteValid ? supWriteData : portWriteData;
        if (wrAny)
        begin
            case (wrReg)
                `PDB_REG_TRIGGER: st_next.trig = wrData;
                `PDB_REG_PC_ADDR: st_next.pcAddr = wrData;
                `PDB_REG_PC_MASK: st_next.pcMask = wrData;
                `PDB_REG_DATA_VAL: st_next.dataVal = wrData;
                `PDB_REG_DATA_MASK: st_next.dataMask = wrData;
                default: st_next.trig = st_reg.trig;
            endcase
            if (wrReg == `PDB_REG_TRIGGER)
            begin
                st_next.state = pdb_pkg::PDB_LEVEL1;
            end
        end
        // Port memory data lands in the data value register, losing the old pattern.
        if (portMem)
        begin
            st_next.dataVal = portMemData;
        end
        // Only the data value and PC address read back over the port.
        if (portRd)
        begin
            st_next.readValid = 1'b1;
            case (portRegNum)
                `PDB_REG_DATA_VAL: st_next.readData = st_reg.dataVal;
                `PDB_REG_PC_ADDR: st_next.readData = st_reg.pcAddr;
                default: st_next.readData = 32'h0000_0000;
            endcase
        end
        // Lane selection by size and address.
        case (busSize)
            `PDB_SZ_BYTE: laneMask = 32'hFF00_0000 >> {busAddrLow, 3'h0};
            `PDB_SZ_WORD: laneMask = busAddrLow[1] ? 32'h0000_FFFF : 32'hFFFF_0000;
            `PDB_SZ_LONG: laneMask = 32'hFFFF_FFFF;
            default: laneMask = 32'h0000_0000;
        endcase
        lvl = (st_reg.state == pdb_pkg::PDB_LEVEL2) ? st_reg.trig[31:16] : st_reg.trig[15:0];
        pcRaw = &((pcValue ~^ st_reg.pcAddr) | st_reg.pcMask);
        dataRaw = ((busData ~^ st_reg.dataVal) | st_reg.dataMask) | ~laneMask;
        dataEn = |lvl[`PDB_F_EDLW:`PDB_F_EDUU];
        pcCond = pcValid & lvl[`PDB_F_EPC] & (pcRaw ^ lvl[`PDB_F_PCI]);
        dataCond = busDataValid & dataEn & ((&dataRaw) ^ lvl[`PDB_F_DI]);
        if (st_reg.state == pdb_pkg::PDB_LEVEL2 ? st_reg.trig[`PDB_L2_SEL] : st_reg.trig[`PDB_L1_SEL])
        begin
            fire = pcCond | dataCond;
        end
        else
        begin
            fire = (pcCond | ~lvl[`PDB_F_EPC]) & (dataCond | ~dataEn) &
                (lvl[`PDB_F_EPC] | dataEn) & (pcValid | busDataValid);
        end
        fire = fire & st_reg.trig[`PDB_F_EBL] & (st_reg.state != pdb_pkg::PDB_FIRED);
        st_next.pcHit = pcCond;
        st_next.dataHit = dataCond;
        if (fire && !(wrAny && wrReg == `PDB_REG_TRIGGER))
        begin
            // A nonzero upper half arms a second level before responding.
            if (st_reg.state == pdb_pkg::PDB_LEVEL1 && st_reg.trig[31:16] != 16'h0000)
            begin
                st_next.state = pdb_pkg::PDB_LEVEL2;
            end
            else
            begin
                st_next.state = pdb_pkg::PDB_FIRED;
                st_next.show = 1'b1;
                st_next.halt = (lvl[`PDB_F_TRC_HI:`PDB_F_TRC_LO] == `PDB_RSP_HALT);
                st_next.irq = (lvl[`PDB_F_TRC_HI:`PDB_F_TRC_LO] == `PDB_RSP_IRQ);
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            st_reg <= '0;
            st_reg.trig <= `PDB_TRIG_RESET;
            st_reg.state <= pdb_pkg::PDB_LEVEL1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign portReadData = st_reg.readData;
    assign portReadValid = st_reg.readValid;
    assign pcMatch = st_reg.pcHit;
    assign dataMatch = st_reg.dataHit;
    assign triggerShow = st_reg.show;
    assign haltRequest = st_reg.halt;
    assign debugInterrupt = st_reg.irq;

    // ==========================================================
    // Checks
    trig_write_a: assert property (@(posedge clk) disable iff (!reset_n)
        supWriteValid && supWriteReg == `PDB_REG_TRIGGER |=> st_reg.trig == $past(supWriteData))
        else $error("Trigger definition write lost.");
    mem_over_a: assert property (@(posedge clk) disable iff (!reset_n)
        portMem |=> st_reg.dataVal == $past(portMemData))
        else $error("Port memory data did not overwrite value.");
    mask_write_a: assert property (@(posedge clk) disable iff (!reset_n)
        supWriteValid && supWriteReg == `PDB_REG_DATA_MASK |=> st_reg.dataMask == $past(supWriteData))
        else $error("Data mask write lost.");
    enable_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
        !st_reg.trig[`PDB_F_EBL] && !st_reg.trig[16+`PDB_F_EBL] |=> !triggerShow)
        else $error("Trigger fired while disabled.");
    pc_valid_a: assert property (@(posedge clk) disable iff (!reset_n)
        !pcValid |=> !pcMatch)
        else $error("PC match without valid PC.");
    data_valid_a: assert property (@(posedge clk) disable iff (!reset_n)
        !busDataValid |=> !dataMatch)
        else $error("Data match without valid transfer.");
    halt_code_a: assert property (@(posedge clk) disable iff (!reset_n)
        haltRequest |-> triggerShow && !debugInterrupt)
        else $error("Halt without trigger show.");
    show_once_a: assert property (@(posedge clk) disable iff (!reset_n)
        triggerShow |=> !triggerShow)
        else $error("Trigger response longer than one cycle.");
    pc_cmp_a: assert property (@(posedge clk) disable iff (!reset_n)
        pcValid && st_reg.trig[`PDB_F_EPC] && !st_reg.trig[`PDB_F_PCI]
        && st_reg.state == pdb_pkg::PDB_LEVEL1
        && ((pcValue ^ st_reg.pcAddr) & ~st_reg.pcMask) == 32'h0000_0000 |=> pcMatch)
        else $error("Masked PC compare missed.");

endmodule

// ===== tb/pdb_debug_host.sv
// Purpose: Debug serial port host model.
// Assumes: The device syncs each strobe through two flops.
// Notes: Released data lines show the inverse of the last value.
`timescale 1ns/1ps
module pdb_debug_host
(
    input wire logic clk,
    output logic portWriteStrobe,
    output logic portReadStrobe,
    output logic [3:0] portRegNum,
    output logic [31:0] portWriteData,
    output logic portMemValid,
    output logic [31:0] portMemData
);
    // ====
    // Access kinds: 0 write, 1 read, 2 memory.
    initial
    begin
        portWriteStrobe = 1'h0;
        portReadStrobe = 1'h0;
        portMemValid = 1'h0;
        portRegNum = 4'h0;
        portWriteData = 32'h0;
        portMemData = 32'h0;
    end
    task automatic access(input logic [1:0] kind, input logic [3:0] r, input logic [31:0] d);
        portRegNum <= r;
        portWriteData <= d;
        portMemData <= d;
        portWriteStrobe <= (kind == 2'h0);
        portReadStrobe <= (kind == 2'h1);
        portMemValid <= (kind == 2'h2);
        // Four cycles cover the sync delay, so data is never sampled mid-change.
        repeat (4) @(posedge clk);
        portWriteStrobe <= 1'h0;
        portReadStrobe <= 1'h0;
        portMemValid <= 1'h0;
        portRegNum <= ~r;
        portWriteData <= ~d;
        portMemData <= ~d;
        repeat (3) @(posedge clk);
    endtask
endmodule

// ===== tb/tb_pc_data_breakpoint_compare.sv
// Purpose: Self-checking bench for the breakpoint comparator.
// Assumes: The host model drives the debug serial port pins.
// Notes: Each trigger register write rearms the one-shot trigger.
`timescale 1ns/1ps
`include "pdb_defines.svh"
`define PDB_CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
    $display("wrong value at %0t: %h expected %h", $time, a, b); end end
module tb_pc_data_breakpoint_compare;
    logic clk, reset_n, supWriteValid, pcValid, busDataValid;
    logic portWriteStrobe, portReadStrobe, portMemValid, portReadValid;
    logic pcMatch, dataMatch, triggerShow, haltRequest, debugInterrupt;
    logic [3:0] supWriteReg, portRegNum;
    logic [1:0] busAddrLow, busSize;
    logic [31:0] supWriteData, portWriteData, portMemData, pcValue, busData;
    logic [31:0] portReadData, rdData;
    int n_errors, num_checks, rdCount;
    // ====
    // Data cases: expected match, address low bits, size, bus data.
    logic [36:0] dcase [10] = '{{3'h4, `PDB_SZ_LONG, 32'h11223344},
        {3'h3, `PDB_SZ_LONG, 32'h11223345}, {3'h4, `PDB_SZ_BYTE, 32'h11FFFFFF},
        {3'h5, `PDB_SZ_BYTE, 32'hFF22FFFF}, {3'h1, `PDB_SZ_BYTE, 32'h11FFFFFF},
        {3'h6, `PDB_SZ_BYTE, 32'hFFFF33FF}, {3'h7, `PDB_SZ_BYTE, 32'hFFFFFF44},
        {3'h4, `PDB_SZ_WORD, 32'h1122FFFF}, {3'h6, `PDB_SZ_WORD, 32'hFFFF3344},
        {3'h2, `PDB_SZ_WORD, 32'h1122FFFF}};
    pdb_breakpoint uut (.clk, .reset_n, .supWriteValid, .supWriteReg, .supWriteData,
        .portWriteStrobe, .portReadStrobe, .portRegNum, .portWriteData, .portMemValid,
        .portMemData, .pcValid, .pcValue, .busDataValid, .busData, .busAddrLow, .busSize,
        .portReadData, .portReadValid, .pcMatch, .dataMatch, .triggerShow, .haltRequest,
        .debugInterrupt);
    pdb_debug_host host (.clk, .portWriteStrobe, .portReadStrobe, .portRegNum,
        .portWriteData, .portMemValid, .portMemData);
    initial
    begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end
    // Captured on the falling edge so the registered answer has settled.
    always @(negedge clk)
        if (portReadValid === 1'h1)
        begin
            rdCount++;
            rdData = portReadData;
        end
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic sw(input logic [3:0] r, input logic [31:0] d);
        supWriteValid <= 1'h1;
        supWriteReg <= r;
        supWriteData <= d;
        @(posedge clk);
        supWriteValid <= 1'h0;
        @(posedge clk);
    endtask
    task automatic fire(input logic pv, dv, input logic [31:0] v, input logic [3:0] asz,
        input logic [4:0] m, exp);
        pcValid <= pv;
        busDataValid <= dv;
        pcValue <= v;
        busData <= v;
        {busAddrLow, busSize} <= asz;
        @(posedge clk);
        pcValid <= 1'h0;
        busDataValid <= 1'h0;
        #1;
        `PDB_CHK({pcMatch, dataMatch, triggerShow, haltRequest, debugInterrupt} & m, exp)
        @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] r, input logic [31:0] e);
        int c;
        c = rdCount;
        host.access(2'h1, r, 32'h0);
        `PDB_CHK(rdCount, c + 1)
        `PDB_CHK(rdData, e)
    endtask
    initial
    begin
        #(25 * 5000);
        n_errors++;
        summarize();
    end
    // ====
    // Main sequence.
    initial
    begin
        {reset_n, supWriteValid, pcValid, busDataValid, busAddrLow, busSize} = 8'h0;
        {supWriteReg, supWriteData, pcValue, busData} = 100'h0;
        n_errors = 0;
        num_checks = 0;
        rdCount = 0;
        repeat (6) @(posedge clk);
        reset_n <= 1'h1;
        @(posedge clk);
        fire(1'h1, 1'h0, 32'h0, 4'h0, 5'h07, 5'h00);
        sw(`PDB_REG_PC_ADDR, 32'h1230);
        sw(`PDB_REG_PC_MASK, 32'hF);
        for (int rc = 0; rc < 3; rc++)
        begin
            sw(`PDB_REG_TRIGGER, {16'h0, rc[1:0], 14'h2002});
            fire(1'h1, 1'h0, 32'h123C, 4'h0, 5'h1F, {3'h5, rc == 1, rc == 2});
            fire(1'h1, 1'h0, 32'h123C, 4'h0, 5'h07, 5'h00);
        end
        sw(`PDB_REG_TRIGGER, 32'h2002);
        fire(1'h1, 1'h0, 32'h1330, 4'h0, 5'h1F, 5'h00);
        sw(`PDB_REG_TRIGGER, 32'h0002);
        fire(1'h1, 1'h0, 32'h1230, 4'h0, 5'h07, 5'h00);
        sw(`PDB_REG_DATA_VAL, 32'h11223344);
        sw(`PDB_REG_DATA_MASK, 32'h0);
        foreach (dcase[i])
        begin
            sw(`PDB_REG_TRIGGER, 32'h3000);
            fire(1'h0, 1'h1, dcase[i][31:0], dcase[i][35:32], 5'h1F,
                {1'h0, {2{dcase[i][36]}}, 2'h0});
        end
        sw(`PDB_REG_TRIGGER, 32'h2002_3000);
        fire(1'h1, 1'h0, 32'h1230, 4'h0, 5'h07, 5'h00);
        fire(1'h0, 1'h1, 32'h11223344, 4'h0, 5'h07, 5'h00);
        fire(1'h1, 1'h0, 32'h1230, 4'h0, 5'h07, 5'h04);
        host.access(2'h0, `PDB_REG_DATA_MASK, 32'hFF);
        sw(`PDB_REG_TRIGGER, 32'h3000);
        fire(1'h0, 1'h1, 32'h112233AA, 4'h0, 5'h1F, 5'h0C);
        host.access(2'h0, `PDB_REG_DATA_VAL, 32'hCAFE0001);
        rd(`PDB_REG_DATA_VAL, 32'hCAFE0001);
        rd(`PDB_REG_DATA_MASK, 32'h0);
        rd(`PDB_REG_PC_ADDR, 32'h1230);
        host.access(2'h2, 4'h0, 32'hBADF00D);
        rd(`PDB_REG_DATA_VAL, 32'hBADF00D);
        host.access(2'h0, `PDB_REG_TRIGGER, 32'h2002);
        fire(1'h1, 1'h0, 32'h1230, 4'h0, 5'h07, 5'h04);
        rd(`PDB_REG_TRIGGER, 32'h0);
        summarize();
    end
endmodule
